/* apb_host.sv */
// Purpose: host side model issuing register transfers over APB
// Assumes: one clock domain, mclk
// Notes:   waits for pready under a bounded count
module apb_host (
  // bus
  input  wire logic        mclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel    = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite  = 1'b0,
  output logic [11:0]      paddr   = 12'h000,
  output logic [31:0]      pwdata  = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] q, output logic e);
    int k;
    k = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 16)
    begin
      @(posedge mclk);
      k++;
    end
    if (k == 16)
    begin
      tb.miscompares++;
      tb.end_of_test();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : rw
endmodule : apb_host

/* gate_error_timer.sv */
// Purpose: fifo gate error flag and elapsed output-data-rate period count
// Assumes: odrTick is a one-cycle pulse per output data period
// Notes:   the count saturates at its top value
module gate_error_timer (
  // clock and reset
  input  wire logic                                mclk,
  input  wire logic                                rst,
  // events
  input  wire logic                                gateError,
  input  wire logic                                fifoEmpty,
  input  wire logic                                odrTick,
  // status
  output logic                                     fgerr,
  output logic [sensor_status_pkg::FGT_W-1:0]      fgt
);

  logic fgerr_reg;
  logic [sensor_status_pkg::FGT_W-1:0] fgt_reg;

  always_ff @(posedge mclk)
  begin
    if (rst)
      fgerr_reg <= 1'b0;
    else if (gateError)
      fgerr_reg <= 1'b1;
    else if (fifoEmpty)
      fgerr_reg <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    // cleared together with the flag so a read never shows a stale count
    if (rst || !fgerr_reg || (fifoEmpty && !gateError))
      fgt_reg <= '0;
    else if (odrTick && !(&fgt_reg))
      fgt_reg <= fgt_reg + 1'b1;
  end

  assign fgerr = fgerr_reg;
  assign fgt   = fgt_reg;

  a_fgt_zero_clear: assert property (@(posedge mclk) disable iff (rst)
    !fgerr |-> fgt == '0) else $error("gate count not zero without flag");

  a_fgerr_holds: assert property (@(posedge mclk) disable iff (rst)
    fgerr && !fifoEmpty |=> fgerr) else $error("gate error flag dropped early");

endmodule : gate_error_timer

/* mode_sequencer.sv */
// Purpose: standby, wake and sleep sequencing with auto-sleep
// Assumes: activity and wakeEvent come from the event detectors on mclk
// Notes:   inactivity is counted in output data periods
module mode_sequencer (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst,
  // control
  input  wire logic                          active,
  input  wire logic                          autoSleepEn,
  input  wire logic [7:0]                    sleepLimit,
  // events
  input  wire logic                          odrTick,
  input  wire logic                          activity,
  input  wire logic                          wakeEvent,
  // status
  output sensor_status_pkg::sys_mode_t       mode,
  output logic                               aslpEvent
);

  sensor_status_pkg::sys_mode_t mode_reg;
  sensor_status_pkg::sys_mode_t mode_next;
  logic [7:0] inact_reg;
  logic       aslpEvent_reg;
  logic       expire;

  assign expire = odrTick && !activity && inact_reg == sleepLimit;

  always_ff @(posedge mclk)
  begin
    if (rst || activity || mode_reg != sensor_status_pkg::MODE_WAKE)
      inact_reg <= '0;
    else if (odrTick && !(&inact_reg))
      inact_reg <= inact_reg + 1'b1;
  end

  always_comb
  begin
    mode_next = mode_reg;
    unique case (mode_reg)
      sensor_status_pkg::MODE_STANDBY:
        if (active)
          mode_next = sensor_status_pkg::MODE_WAKE;
      sensor_status_pkg::MODE_WAKE:
        if (!active)
          mode_next = sensor_status_pkg::MODE_STANDBY;
        else if (autoSleepEn && expire)
          mode_next = sensor_status_pkg::MODE_SLEEP;
      sensor_status_pkg::MODE_SLEEP:
        if (!active)
          mode_next = sensor_status_pkg::MODE_STANDBY;
        else if (wakeEvent || !autoSleepEn)
          mode_next = sensor_status_pkg::MODE_WAKE;
      default:
        mode_next = sensor_status_pkg::MODE_STANDBY;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      mode_reg <= sensor_status_pkg::MODE_STANDBY;
    else
      mode_reg <= mode_next;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      aslpEvent_reg <= 1'b0;
    else
      aslpEvent_reg <= active && autoSleepEn &&
        ((mode_reg == sensor_status_pkg::MODE_WAKE && expire) ||
         (mode_reg == sensor_status_pkg::MODE_SLEEP && wakeEvent));
  end

  assign mode      = mode_reg;
  assign aslpEvent = aslpEvent_reg;

  a_sleep_entry: assert property (@(posedge mclk) disable iff (rst)
    mode == sensor_status_pkg::MODE_WAKE && active && autoSleepEn && expire
    |=> mode == sensor_status_pkg::MODE_SLEEP && aslpEvent)
    else $error("no sleep entry after inactivity limit");

  a_wake_entry: assert property (@(posedge mclk) disable iff (rst)
    mode == sensor_status_pkg::MODE_SLEEP && active && wakeEvent
    |=> mode == sensor_status_pkg::MODE_WAKE)
    else $error("no wake on wake event");

endmodule : mode_sequencer

/* sensor_mode_and_irq_status.sv */
// Purpose: system mode and interrupt source status with APB access
// Assumes: event and source-read strobes are on mclk; APB zero wait state
// Notes:   read data is captured in the setup phase; clears mask on what was shown
module sensor_mode_and_irq_status (
  // clock and reset
  input  wire logic                                     mclk,
  input  wire logic                                     rst,
  // apb slave
  input  wire logic                                     psel,
  input  wire logic                                     penable,
  input  wire logic                                     pwrite,
  input  wire logic [sensor_status_pkg::PADDR_W-1:0]    paddr,
  input  wire logic [31:0]                              pwdata,
  output logic [31:0]                                   prdata,
  output logic                                          pready,
  output logic                                          pslverr,
  // event detectors and neighbouring registers
  input  wire sensor_status_pkg::sensor_events_t        events,
  input  wire sensor_status_pkg::src_reads_t            srcReads,
  input  wire logic                                     odrTick,
  // sensor data read path
  output logic [7:0]                                    sensorAddr,
  input  wire logic [7:0]                               sensorData,
  // rate and mode status
  output sensor_status_pkg::sys_mode_t                  sysMode,
  output logic                                          useSleepRate,
  output logic [2:0]                                    rateCode,
  output logic [1:0]                                    sleepRateCode
);

  logic [9:0]  config_reg;
  logic [7:0]  irqEn_reg;
  logic [7:0]  sleepLim_reg;
  logic [7:0]  flags_reg;
  logic [7:0]  setVec;
  logic [7:0]  clrVec;
  logic [31:0] prdata_reg;
  logic        shownAslp_reg;
  logic        fifoCond_reg;
  logic [3:0]  burstIdx_reg;
  logic [7:0]  sensorAddr_reg;
  logic        useSleep_reg;
  logic [2:0]  rateCode_reg;
  logic [1:0]  sleepRate_reg;

  logic        setupRd;
  logic        wrDone;
  logic        rdDone;
  logic        mapped;
  logic [7:0]  rdValue;
  logic        fgerr;
  logic [sensor_status_pkg::FGT_W-1:0] fgt;
  logic        aslpEvent;
  logic        fifoCond;
  logic        drdyNew;
  logic        drdyClear;
  logic [3:0]  burstFirst;
  logic [3:0]  burstEnd;
  sensor_status_pkg::sens_mode_t sensMode;

  function automatic logic hit(input logic [sensor_status_pkg::PADDR_W-1:0] a,
                               input logic [9:0] idx);
    hit = a == {idx, 2'b00};
  endfunction : hit

  // apb handshake
  assign setupRd = psel && !penable && !pwrite;
  assign wrDone  = psel && penable && pwrite;
  assign rdDone  = psel && penable && !pwrite;
  assign mapped  = hit(paddr, sensor_status_pkg::IDX_SYSMODE) ||
                   hit(paddr, sensor_status_pkg::IDX_INTSRC) ||
                   hit(paddr, sensor_status_pkg::IDX_CONFIG) ||
                   hit(paddr, sensor_status_pkg::IDX_IRQEN) ||
                   hit(paddr, sensor_status_pkg::IDX_SLEEPLIM) ||
                   hit(paddr, sensor_status_pkg::IDX_DATAPORT);
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_reg;

  assign sensMode = sensor_status_pkg::sens_mode_t'(
                      config_reg[sensor_status_pkg::CFG_SMODE +: 2]);

  // writable registers
  always_ff @(posedge mclk)
  begin
    if (rst)
      config_reg <= sensor_status_pkg::CONFIG_RST;
    else if (wrDone && hit(paddr, sensor_status_pkg::IDX_CONFIG))
      config_reg <= pwdata[9:0];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      irqEn_reg <= sensor_status_pkg::IRQEN_RST;
    else if (wrDone && hit(paddr, sensor_status_pkg::IDX_IRQEN))
      irqEn_reg <= pwdata[7:0];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      sleepLim_reg <= sensor_status_pkg::SLEEPLIM_RST;
    else if (wrDone && hit(paddr, sensor_status_pkg::IDX_SLEEPLIM))
      sleepLim_reg <= pwdata[7:0];
  end

  mode_sequencer u_mode (
    .mclk        (mclk),
    .rst         (rst),
    .active      (config_reg[sensor_status_pkg::CFG_ACTIVE]),
    .autoSleepEn (config_reg[sensor_status_pkg::CFG_ASLPEN]),
    .sleepLimit  (sleepLim_reg),
    .odrTick     (odrTick),
    .activity    (events.activity),
    .wakeEvent   (events.wakeEvent),
    .mode        (sysMode),
    .aslpEvent   (aslpEvent)
  );

  gate_error_timer u_gate (
    .mclk      (mclk),
    .rst       (rst),
    .gateError (events.gateError),
    .fifoEmpty (events.fifoEmpty),
    .odrTick   (odrTick),
    .fgerr     (fgerr),
    .fgt       (fgt)
  );

  // rate selection follows the mode
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      useSleep_reg  <= 1'b0;
      rateCode_reg  <= '0;
      sleepRate_reg <= '0;
    end
    else
    begin
      useSleep_reg  <= sysMode == sensor_status_pkg::MODE_SLEEP;
      rateCode_reg  <= config_reg[sensor_status_pkg::CFG_DR +: 3];
      sleepRate_reg <= config_reg[sensor_status_pkg::CFG_SLRATE +: 2];
    end
  end

  assign useSleepRate  = useSleep_reg;
  assign rateCode      = rateCode_reg;
  assign sleepRateCode = sleepRate_reg;

  // read data captured in setup phase
  always_comb
  begin
    rdValue = 8'h00;
    if (hit(paddr, sensor_status_pkg::IDX_SYSMODE))
      rdValue = {fgerr, fgt, sysMode};
    else if (hit(paddr, sensor_status_pkg::IDX_INTSRC))
      rdValue = flags_reg;
    else if (hit(paddr, sensor_status_pkg::IDX_CONFIG))
      rdValue = config_reg[7:0];
    else if (hit(paddr, sensor_status_pkg::IDX_IRQEN))
      rdValue = irqEn_reg;
    else if (hit(paddr, sensor_status_pkg::IDX_SLEEPLIM))
      rdValue = sleepLim_reg;
    else if (hit(paddr, sensor_status_pkg::IDX_DATAPORT))
      rdValue = sensorData;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      prdata_reg <= '0;
    else if (setupRd)
    begin
      if (hit(paddr, sensor_status_pkg::IDX_CONFIG))
        prdata_reg <= {22'h0, config_reg};
      else
        prdata_reg <= {24'h000000, rdValue};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      shownAslp_reg <= 1'b0;
    else if (setupRd)
      shownAslp_reg <= flags_reg[sensor_status_pkg::SRC_ASLP];
  end

  // fifo condition edge and sample re-arm
  assign fifoCond = events.fifoOverflow || events.fifoWatermark;

  always_ff @(posedge mclk)
  begin
    if (rst)
      fifoCond_reg <= 1'b0;
    else
      fifoCond_reg <= fifoCond;
  end

  // data ready per sensor mode
  always_comb
  begin
    unique case (sensMode)
      sensor_status_pkg::SENS_ACCEL:
        drdyNew = events.accelNew;
      sensor_status_pkg::SENS_MAG:
        drdyNew = events.magNew;
      sensor_status_pkg::SENS_HYBRID:
        drdyNew = events.accelNew || events.magNew;
      default:
        drdyNew = 1'b0;
    endcase
  end

  // sensor data burst pointer
  assign burstFirst = (sensMode == sensor_status_pkg::SENS_MAG) ?
                      sensor_status_pkg::ACCEL_BYTES : 4'h0;
  assign burstEnd   = (sensMode == sensor_status_pkg::SENS_MAG ||
                      (sensMode == sensor_status_pkg::SENS_HYBRID &&
                       config_reg[sensor_status_pkg::CFG_AUTOINC])) ?
                      sensor_status_pkg::BURST_BYTES : sensor_status_pkg::ACCEL_BYTES;

  always_ff @(posedge mclk)
  begin
    if (rst)
      burstIdx_reg <= 4'h0;
    else if (wrDone && hit(paddr, sensor_status_pkg::IDX_DATAPORT))
      burstIdx_reg <= burstFirst;
    else if (rdDone && hit(paddr, sensor_status_pkg::IDX_DATAPORT))
    begin
      if (burstIdx_reg + 4'h1 >= burstEnd)
        burstIdx_reg <= burstFirst;
      else
        burstIdx_reg <= burstIdx_reg + 4'h1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      sensorAddr_reg <= sensor_status_pkg::BURST_START;
    else
      sensorAddr_reg <= sensor_status_pkg::BURST_START + {4'h0, burstIdx_reg};
  end

  assign sensorAddr = sensorAddr_reg;

  assign drdyClear = rdDone && hit(paddr, sensor_status_pkg::IDX_DATAPORT) &&
                     ((sensMode == sensor_status_pkg::SENS_ACCEL &&
                       burstIdx_reg == 4'h0) ||
                      (sensMode != sensor_status_pkg::SENS_ACCEL &&
                       burstIdx_reg == sensor_status_pkg::ACCEL_BYTES));

  // flag set and clear terms
  always_comb
  begin
    setVec = 8'h00;
    clrVec = 8'h00;
    setVec[sensor_status_pkg::SRC_ASLP]   = aslpEvent;
    setVec[sensor_status_pkg::SRC_FIFO]   = fifoCond &&
                                            (!fifoCond_reg || events.fifoSampleIn);
    setVec[sensor_status_pkg::SRC_TRANS]  = events.transientActive;
    setVec[sensor_status_pkg::SRC_ORIENT] = events.orientChanged;
    setVec[sensor_status_pkg::SRC_PULSE]  = events.pulseActive;
    setVec[sensor_status_pkg::SRC_FFMT]   = events.ffmtActive;
    setVec[sensor_status_pkg::SRC_VECM]   = events.vecmIrq;
    setVec[sensor_status_pkg::SRC_DRDY]   = drdyNew;
    setVec = setVec & irqEn_reg;
    clrVec[sensor_status_pkg::SRC_ASLP]   = rdDone && shownAslp_reg &&
                                            hit(paddr, sensor_status_pkg::IDX_SYSMODE);
    clrVec[sensor_status_pkg::SRC_FIFO]   = srcReads.fifoStatus;
    clrVec[sensor_status_pkg::SRC_TRANS]  = srcReads.transientSrc;
    clrVec[sensor_status_pkg::SRC_ORIENT] = srcReads.orientStatus;
    clrVec[sensor_status_pkg::SRC_PULSE]  = srcReads.pulseSrc;
    clrVec[sensor_status_pkg::SRC_FFMT]   = srcReads.ffmtSrc;
    clrVec[sensor_status_pkg::SRC_VECM]   = rdDone &&
                                            prdata_reg[sensor_status_pkg::SRC_VECM] &&
                                            hit(paddr, sensor_status_pkg::IDX_INTSRC);
    clrVec[sensor_status_pkg::SRC_DRDY]   = drdyClear;
  end

  // sticky flags, set wins over clear
  genvar i;
  generate
    for (i = 0; i < sensor_status_pkg::REG_W; i++)
    begin : g_flag
      always_ff @(posedge mclk)
      begin
        if (rst)
          flags_reg[i] <= sensor_status_pkg::FLAGS_RST[i];
        else if (setVec[i])
          flags_reg[i] <= 1'b1;
        else if (clrVec[i])
          flags_reg[i] <= 1'b0;
      end
    end
  endgenerate

  a_aslp_read_clear: assert property (@(posedge mclk) disable iff (rst)
    rdDone && hit(paddr, sensor_status_pkg::IDX_SYSMODE) && shownAslp_reg &&
    !setVec[sensor_status_pkg::SRC_ASLP]
    |=> !flags_reg[sensor_status_pkg::SRC_ASLP])
    else $error("auto-sleep flag not cleared by mode read");

  a_intsrc_keeps: assert property (@(posedge mclk) disable iff (rst)
    rdDone && hit(paddr, sensor_status_pkg::IDX_INTSRC) && srcReads == '0
    |=> (flags_reg[7:2] & $past(flags_reg[7:2])) == $past(flags_reg[7:2]))
    else $error("source register read cleared a foreign flag");

  a_vecm_read_clear: assert property (@(posedge mclk) disable iff (rst)
    rdDone && hit(paddr, sensor_status_pkg::IDX_INTSRC) &&
    prdata[sensor_status_pkg::SRC_VECM] && !setVec[sensor_status_pkg::SRC_VECM]
    |=> !flags_reg[sensor_status_pkg::SRC_VECM])
    else $error("vector flag not cleared by source read");

  a_fifo_rearm: assert property (@(posedge mclk) disable iff (rst)
    fifoCond && events.fifoSampleIn && irqEn_reg[sensor_status_pkg::SRC_FIFO]
    |=> flags_reg[sensor_status_pkg::SRC_FIFO])
    else $error("fifo flag not set again on new sample");

  a_trans_set_wins: assert property (@(posedge mclk) disable iff (rst)
    events.transientActive && irqEn_reg[sensor_status_pkg::SRC_TRANS] &&
    srcReads.transientSrc |=> flags_reg[sensor_status_pkg::SRC_TRANS])
    else $error("transient event lost under clearing read");

  a_orient_clear: assert property (@(posedge mclk) disable iff (rst)
    srcReads.orientStatus && !setVec[sensor_status_pkg::SRC_ORIENT]
    |=> !flags_reg[sensor_status_pkg::SRC_ORIENT])
    else $error("orientation flag not cleared");

  a_drdy_accel_only: assert property (@(posedge mclk) disable iff (rst)
    sensMode == sensor_status_pkg::SENS_ACCEL && !flags_reg[0] &&
    events.magNew && !events.accelNew |=> !flags_reg[0])
    else $error("data ready set by magnetic data in accel mode");

  a_mode_reset: assert property (@(posedge mclk)
    rst |=> sysMode == sensor_status_pkg::MODE_STANDBY && flags_reg == 8'h00)
    else $error("mode or flags not cleared by reset");

  a_burst_wrap: assert property (@(posedge mclk) disable iff (rst)
    rdDone && hit(paddr, sensor_status_pkg::IDX_DATAPORT) &&
    burstIdx_reg == 4'hB && burstEnd == sensor_status_pkg::BURST_BYTES
    |=> burstIdx_reg == burstFirst ##1 sensorAddr == sensor_status_pkg::BURST_START +
        {4'h0, burstFirst})
    else $error("burst pointer did not wrap after twelve bytes");

  a_unmapped_err: assert property (@(posedge mclk) disable iff (rst)
    psel && penable && !mapped |-> pslverr && pready)
    else $error("unmapped access not flagged");

endmodule : sensor_mode_and_irq_status

/* sensor_status_pkg.sv */
// Purpose: shared constants and carriers for the mode and interrupt status block
// Assumes: register index times four gives the APB byte address
// Notes:   flag bit positions follow the interrupt source layout
package sensor_status_pkg;

  localparam int unsigned PADDR_W = 12;
  localparam int unsigned REG_W   = 8;

  // register indices
  localparam logic [9:0] IDX_SYSMODE  = 10'h00B;
  localparam logic [9:0] IDX_INTSRC   = 10'h00C;
  localparam logic [9:0] IDX_CONFIG   = 10'h010;
  localparam logic [9:0] IDX_IRQEN    = 10'h011;
  localparam logic [9:0] IDX_SLEEPLIM = 10'h012;
  localparam logic [9:0] IDX_DATAPORT = 10'h013;

  // reset values
  localparam logic [9:0] CONFIG_RST   = 10'h000;
  localparam logic [7:0] IRQEN_RST    = 8'h00;
  localparam logic [7:0] SLEEPLIM_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST    = 8'h00;

  // interrupt source bit positions
  localparam int unsigned SRC_ASLP   = 7;
  localparam int unsigned SRC_FIFO   = 6;
  localparam int unsigned SRC_TRANS  = 5;
  localparam int unsigned SRC_ORIENT = 4;
  localparam int unsigned SRC_PULSE  = 3;
  localparam int unsigned SRC_FFMT   = 2;
  localparam int unsigned SRC_VECM   = 1;
  localparam int unsigned SRC_DRDY   = 0;

  // config field positions
  localparam int unsigned CFG_ACTIVE  = 0;
  localparam int unsigned CFG_ASLPEN  = 1;
  localparam int unsigned CFG_SMODE   = 2;
  localparam int unsigned CFG_AUTOINC = 4;
  localparam int unsigned CFG_DR      = 5;
  localparam int unsigned CFG_SLRATE  = 8;

  localparam int unsigned FGT_W = 5;

  // sensor data burst
  localparam logic [7:0] BURST_START = 8'h01;
  localparam logic [3:0] ACCEL_BYTES = 4'h6;
  localparam logic [3:0] BURST_BYTES = 4'hC;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_WAKE    = 2'b01,
    MODE_SLEEP   = 2'b10
  } sys_mode_t;

  typedef enum logic [1:0] {
    SENS_ACCEL  = 2'b00,
    SENS_MAG    = 2'b01,
    SENS_HYBRID = 2'b11
  } sens_mode_t;

  typedef struct packed {
    logic gateError;
    logic fifoEmpty;
    logic fifoOverflow;
    logic fifoWatermark;
    logic fifoSampleIn;
    logic transientActive;
    logic orientChanged;
    logic pulseActive;
    logic ffmtActive;
    logic vecmIrq;
    logic accelNew;
    logic magNew;
    logic wakeEvent;
    logic activity;
  } sensor_events_t;

  typedef struct packed {
    logic fifoStatus;
    logic transientSrc;
    logic orientStatus;
    logic pulseSrc;
    logic ffmtSrc;
  } src_reads_t;

endpackage : sensor_status_pkg

/* tb.sv */
// Purpose: self-checking bench for mode and interrupt status
// Assumes: zero wait APB, event pulses on mclk
// Notes:   events driven as the packed struct bit image
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic        odrTick = 1'b0;
  logic [13:0] ev = 14'h0000;
  logic [4:0]  sr = 5'h00;
  logic [31:0] prdata, pwdata, q;
  logic [11:0] paddr;
  logic [7:0]  sAddr;
  logic        psel, penable, pwrite, pready, pslverr, e;
  logic        useSleep;
  logic [2:0]  rCode;
  logic [1:0]  sCode;
  sensor_status_pkg::sys_mode_t sMode;
  int          miscompares = 0;
  int          tests_run = 0;
  apb_host u_apb_host (.mclk(mclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  sensor_mode_and_irq_status u_sensor_mode_and_irq_status (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events(sensor_status_pkg::sensor_events_t'(ev)),
    .srcReads(sensor_status_pkg::src_reads_t'(sr)), .odrTick(odrTick),
    .sensorAddr(sAddr), .sensorData(~sAddr), .sysMode(sMode), .useSleepRate(useSleep),
    .rateCode(rCode), .sleepRateCode(sCode));
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    u_apb_host.rw(1'b0, a, 32'h0, q, e);
    chk($sformatf("reg %h", a), q, x);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_apb_host.rw(1'b1, a, d, q, e);
  endtask : wr
  task automatic pulse(input logic [13:0] v, input logic [4:0] r);
    @(posedge mclk);
    ev <= v;
    sr <= r;
    @(posedge mclk);
    ev <= 14'h0000;
    sr <= 5'h00;
  endtask : pulse
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge mclk) odrTick <= 1'b1;
      @(posedge mclk) odrTick <= 1'b0;
    end
  endtask : ticks
  task automatic t_flags();
    rd(12'h02C, 32'h0);
    pulse(14'h0100, 5'h00);
    rd(12'h030, 32'h0);
    u_apb_host.rw(1'b0, 12'h03C, 32'h0, q, e);
    chk("pslverr", {31'h0, e}, 32'h1);
    wr(12'h044, 32'hFF);
    pulse(14'h0010, 5'h00);
    rd(12'h030, 32'h02);
    rd(12'h030, 32'h0);
    pulse(14'h0100, 5'h00);
    rd(12'h030, 32'h20);
    rd(12'h030, 32'h20);
    pulse(14'h0100, 5'h08);
    rd(12'h030, 32'h20);
    pulse(14'h0000, 5'h08);
    rd(12'h030, 32'h0);
    pulse(14'h00E0, 5'h00);
    rd(12'h030, 32'h1C);
    pulse(14'h0000, 5'h04);
    rd(12'h030, 32'h0C);
    pulse(14'h0000, 5'h03);
    rd(12'h030, 32'h0);
  endtask : t_flags
  task automatic t_fifo();
    pulse(14'h0800, 5'h10);
    rd(12'h030, 32'h40);
    @(posedge mclk) ev <= 14'h0800;
    @(posedge mclk) sr <= 5'h10;
    @(posedge mclk) sr <= 5'h00;
    rd(12'h030, 32'h0);
    @(posedge mclk) ev <= 14'h0A00;
    @(posedge mclk) ev <= 14'h0800;
    rd(12'h030, 32'h40);
    pulse(14'h0000, 5'h10);
    pulse(14'h0400, 5'h00);
    rd(12'h030, 32'h40);
    pulse(14'h0000, 5'h10);
  endtask : t_fifo
  task automatic t_gate();
    pulse(14'h2000, 5'h00);
    ticks(3);
    rd(12'h02C, 32'h8C);
    pulse(14'h1000, 5'h00);
    rd(12'h02C, 32'h0);
  endtask : t_gate
  task automatic t_mode();
    wr(12'h048, 32'h1);
    wr(12'h040, 32'h2A3);
    rd(12'h02C, 32'h1);
    rd(12'h040, 32'h2A3);
    chk("rateCode", {29'h0, rCode}, 32'h5);
    chk("sleepRateCode", {30'h0, sCode}, 32'h2);
    ticks(3);
    rd(12'h030, 32'h80);
    rd(12'h02C, 32'h2);
    chk("sysMode", {30'h0, sMode}, 32'h2);
    chk("useSleepRate", {31'h0, useSleep}, 32'h1);
    rd(12'h030, 32'h0);
    pulse(14'h0002, 5'h00);
    rd(12'h030, 32'h80);
    rd(12'h02C, 32'h1);
    chk("useSleepRate", {31'h0, useSleep}, 32'h0);
  endtask : t_mode
  task automatic t_data();
    int j;
    pulse(14'h0004, 5'h00);
    rd(12'h030, 32'h0);
    pulse(14'h0008, 5'h00);
    rd(12'h030, 32'h1);
    wr(12'h04C, 32'h0);
    rd(12'h04C, 32'hFE);
    rd(12'h04C, 32'hFD);
    rd(12'h030, 32'h0);
    chk("sensorAddr", {24'h0, sAddr}, 32'h3);
    wr(12'h040, 32'h2BF);
    pulse(14'h0004, 5'h00);
    rd(12'h030, 32'h1);
    wr(12'h04C, 32'h0);
    for (j = 0; j < 13; j++)
      rd(12'h04C, {24'h0, ~(8'h01 + 8'(j % 12))});
    rd(12'h030, 32'h0);
  endtask : t_data
  task automatic end_of_test();
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_flags();
    t_fifo();
    t_gate();
    t_mode();
    t_data();
    end_of_test();
  end
endmodule : tb
